// ### verilog/gasc_cfg.svh
`ifndef GASC_CFG_SVH
`define GASC_CFG_SVH
`define GASC_ADDR_W 4
`define GASC_DATA_W 8
`define GASC_FRAME_W 12
`define GASC_REG_POWER_GAIN 4'h0
`define GASC_REG_INIT 4'h1
`define GASC_PC_MSB 7
`define GASC_PC_LSB 6
`define GASC_GC_MSB 5
`define GASC_GC_LSB 0
`define GASC_PG_RESET 8'hFD
`define GASC_PC_RESET 2'h3
`define GASC_GC_RESET 6'h3D
`define GASC_INIT_VALUE 8'h00
`define GASC_POWERUP_US 100
`define GASC_CORE_MHZ 100
`define GASC_POWERUP_CYC (`GASC_POWERUP_US * `GASC_CORE_MHZ)
`define GASC_SCLK_DIV 10
`endif

// ### verilog/gasc_pkg.sv
package gasc_pkg;
  typedef enum logic [1:0] {
    GASC_IDLE = 2'b00,
    GASC_SHIFT = 2'b01,
    GASC_GAP = 2'b10,
    GASC_WAIT = 2'b11
  } gasc_host_state_type;
endpackage

// ### verilog/gasc_link_if.sv
`timescale 1ns/10ps
`default_nettype none
interface gasc_link_if;
  logic cs_n;
  logic sclk;
  logic sda;
  logic transmit_on_pin;
  modport host (output cs_n, output sclk, output sda, output transmit_on_pin);
  modport dev (input cs_n, input sclk, input sda, input transmit_on_pin);
endinterface
`default_nettype wire

// ### verilog/gasc_sync2.sv
`timescale 1ns/10ps
`default_nettype none
module gasc_sync2 (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Level in and out
  input wire logic d,
  output logic q
);
  logic meta_ff;
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      meta_ff <= 1'b0;
      q <= 1'b0;
    end
    else
    begin
      meta_ff <= d;
      q <= meta_ff;
    end
  end
endmodule
`default_nettype wire

// ### verilog/gasc_device.sv
`include "gasc_cfg.svh"
`timescale 1ns/10ps
`default_nettype none
module gasc_device
  import gasc_pkg::*;
(
  // Serial link, device end
  gasc_link_if.dev LINK,
  // Amplifier controls
  output logic [1:0] POWER_CODE,
  output logic [5:0] GAIN_CODE,
  output logic AMP_ACTIVE,
  output logic INIT_WRITTEN
);
  // Shift register runs on the serial clock; frame counter saturates at twelve.
  logic [`GASC_FRAME_W-1:0] shift_ff;
  logic [3:0] count_ff;
  // There is no reset pin, so the applied settings start from their power-up defaults.
  logic [1:0] power_ff = `GASC_PC_RESET;
  logic [5:0] gain_ff = `GASC_GC_RESET;
  logic init_ff = 1'b0;
  always_ff @(posedge LINK.sclk or posedge LINK.cs_n)
  begin
    if (LINK.cs_n)
      count_ff <= 4'h0;
    else if (count_ff != 4'hC)
      count_ff <= count_ff + 4'h1;
  end
  always_ff @(posedge LINK.sclk)
  begin
    if (!LINK.cs_n)
      shift_ff <= {shift_ff[`GASC_FRAME_W-2:0], LINK.sda};
  end
  wire frame_full = (count_ff == 4'hC);
  wire [3:0] frame_addr = shift_ff[11:8];
  wire [7:0] frame_data = shift_ff[7:0];
  wire hit_pg = frame_full && (frame_addr == `GASC_REG_POWER_GAIN);
  wire hit_init = frame_full && (frame_addr == `GASC_REG_INIT);
  // Settings apply on the chip select rising edge only for a whole frame.
  always_ff @(posedge LINK.cs_n)
  begin
    if (hit_pg)
    begin
      power_ff <= frame_data[`GASC_PC_MSB:`GASC_PC_LSB];
      gain_ff <= frame_data[`GASC_GC_MSB:`GASC_GC_LSB];
    end
    if (hit_init)
      init_ff <= (frame_data == `GASC_INIT_VALUE);
  end
  assign POWER_CODE = power_ff;
  assign GAIN_CODE = gain_ff;
  assign INIT_WRITTEN = init_ff;
  assign AMP_ACTIVE = LINK.transmit_on_pin;
endmodule
`default_nettype wire

// ### verilog/gasc_host.sv
`include "gasc_cfg.svh"
`timescale 1ns/10ps
`default_nettype none
module gasc_host
  import gasc_pkg::*;
#(
  parameter int POWERUP_CYC = `GASC_POWERUP_CYC
)
(
  // Clock and reset
  input wire logic CORE_CLK,
  input wire logic RESETN,
  // Write request
  input wire logic WR_REQ,
  input wire logic [3:0] WR_ADDR,
  input wire logic [7:0] WR_DATA,
  output logic WR_READY,
  // Burst control
  input wire logic TX_ON,
  // Serial link, host end
  gasc_link_if.host LINK
);
  gasc_host_state_type state_ff;
  logic [31:0] wait_ff;
  logic [11:0] frame_ff;
  logic [3:0] bit_ff;
  logic [3:0] div_ff;
  logic sclk_ff;
  logic cs_n_ff;
  logic sda_ff;
  logic transmit_on_pin_ff;
  logic tx_sync;
  gasc_sync2 u_tx_sync (
    .clk(CORE_CLK),
    .rst_n(RESETN),
    .d(TX_ON),
    .q(tx_sync)
  );
  wire ready_up = (wait_ff >= POWERUP_CYC[31:0]);
  wire half = (div_ff == 4'(`GASC_SCLK_DIV / 2 - 1));
  assign WR_READY = ready_up && (state_ff == GASC_IDLE) && !transmit_on_pin_ff;
  always_ff @(posedge CORE_CLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      state_ff <= GASC_IDLE;
      wait_ff <= 32'h0;
      frame_ff <= 12'h000;
      bit_ff <= 4'h0;
      div_ff <= 4'h0;
      sclk_ff <= 1'b0;
      cs_n_ff <= 1'b1;
      sda_ff <= 1'b0;
      transmit_on_pin_ff <= 1'b0;
    end
    else
    begin
      if (!ready_up)
        wait_ff <= wait_ff + 32'h1;
      div_ff <= half ? 4'h0 : div_ff + 4'h1;
      case (state_ff)
        GASC_IDLE:
        begin
          transmit_on_pin_ff <= tx_sync;
          if (WR_REQ && WR_READY)
          begin
            frame_ff <= {WR_ADDR[2:0], WR_DATA, 1'b0};
            sda_ff <= WR_ADDR[3];
            cs_n_ff <= 1'b0;
            bit_ff <= 4'h0;
            div_ff <= 4'h0;
            state_ff <= GASC_SHIFT;
          end
        end
        GASC_SHIFT:
          if (half)
          begin
            sclk_ff <= !sclk_ff;
            if (sclk_ff)
            begin
              sda_ff <= frame_ff[11];
              frame_ff <= {frame_ff[10:0], 1'b0};
            end
            else if (bit_ff == 4'hB)
              state_ff <= GASC_GAP;
            else
              bit_ff <= bit_ff + 4'h1;
          end
        GASC_GAP:
          if (half && sclk_ff)
          begin
            sclk_ff <= 1'b0;
            state_ff <= GASC_WAIT;
          end
        GASC_WAIT:
          if (half)
          begin
            cs_n_ff <= 1'b1;
            state_ff <= GASC_IDLE;
          end
        default:
          state_ff <= GASC_IDLE;
      endcase
    end
  end
  assign LINK.cs_n = cs_n_ff;
  assign LINK.sclk = sclk_ff;
  assign LINK.sda = sda_ff;
  assign LINK.transmit_on_pin = transmit_on_pin_ff;
endmodule
`default_nettype wire

// ### dv/gasc_link_assertions.sv
`timescale 1ns/10ps
`default_nettype none
module gasc_link_assertions (
  // Clock and reset
  input wire logic CORE_CLK,
  input wire logic RESETN,
  // Link signals
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic sda,
  input wire logic transmit_on_pin
);
  logic [4:0] rise_cnt_ff;
  default clocking cb @(posedge CORE_CLK);
  endclocking
  default disable iff (!RESETN);
  always_ff @(posedge CORE_CLK or negedge RESETN)
    if (!RESETN)
      rise_cnt_ff <= 5'h00;
    else if (cs_n)
      rise_cnt_ff <= 5'h00;
    else if ($rose(sclk))
      rise_cnt_ff <= rise_cnt_ff + 5'h01;
  chk_idle_clk_low: assert property (cs_n |-> !sclk) else $error("clk idle");
  chk_clk_rate: assert property ($rose(sclk) |=> (!$rose(sclk))[*8]) else $error("fast");
  chk_data_steady: assert property (sclk && $past(sclk) |-> $stable(sda)) else $error("sda");
  chk_twelve_bits: assert property ($rose(cs_n) |-> rise_cnt_ff == 5'h0C) else $error("n");
  chk_frame_span: assert property ($fell(cs_n) |-> ##[100:150] $rose(cs_n)) else $error("len");
  chk_clk_in_frame: assert property ($rose(sclk) |-> !cs_n) else $error("clk out");
  chk_select_setup: assert property ($fell(cs_n) |-> (!sclk)[*2]) else $error("setup");
  chk_tx_off_frame: assert property (!cs_n |-> !transmit_on_pin) else $error("tx");
  cover property ($rose(cs_n));
  cover property ($rose(transmit_on_pin));
  cover property (rise_cnt_ff == 5'h0C);
endmodule
`default_nettype wire

// ### dv/testbench.sv
`timescale 1ns/10ps
`default_nettype none
module testbench;
  logic clk, rst_n, req, tx, rdy, amp, ini;
  logic [3:0] addr;
  logic [7:0] data;
  logic [1:0] pc;
  logic [5:0] gc;
  logic [5:0] gains [3] = '{6'h3F, 6'h03, 6'h2A};
  int num_errors;
  int comparisons;
  gasc_link_if link_inst ();
  gasc_host #(.POWERUP_CYC(20)) gasc_host_inst (.CORE_CLK(clk), .RESETN(rst_n), .WR_REQ(req),
    .WR_ADDR(addr), .WR_DATA(data), .WR_READY(rdy), .TX_ON(tx), .LINK(link_inst.host));
  gasc_device gasc_device_inst (.LINK(link_inst.dev), .POWER_CODE(pc), .GAIN_CODE(gc),
    .AMP_ACTIVE(amp), .INIT_WRITTEN(ini));
  gasc_link_assertions gasc_link_assertions_inst (.CORE_CLK(clk), .RESETN(rst_n),
    .cs_n(link_inst.cs_n), .sclk(link_inst.sclk), .sda(link_inst.sda),
    .transmit_on_pin(link_inst.transmit_on_pin));
  task automatic check(input string n, input logic [7:0] s, input logic [7:0] e);
    comparisons++;
    if (s !== e)
    begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic wait_ready();
    for (int i = 0; i < 300 && rdy !== 1'b1; i++)
      @(negedge clk);
    check("ready", {7'h00, rdy}, 8'h01);
  endtask
  task automatic send(input logic [3:0] a, input logic [7:0] d);
    logic [7:0] old;
    wait_ready();
    old = {pc, gc};
    addr = a;
    data = d;
    req = 1'b1;
    @(negedge clk);
    req = 1'b0;
    repeat (60) @(negedge clk);
    check("held", {pc, gc}, old);
    wait_ready();
  endtask
  task automatic t_defaults();
    wait_ready();
    check("codes", {pc, gc}, 8'hFD);
    check("init", {7'h00, ini}, 8'h00);
  endtask
  task automatic t_ignore();
    send(4'h8, 8'h00);
    check("ignored", {pc, gc}, 8'hFD);
    send(4'h1, 8'h00);
    check("init", {7'h00, ini}, 8'h01);
  endtask
  task automatic t_short();
    logic [7:0] old;
    wait_ready();
    old = {pc, gc};
    addr = 4'h0;
    data = 8'h00;
    req = 1'b1;
    @(negedge clk);
    req = 1'b0;
    repeat (40) @(negedge clk);
    rst_n = 1'b0;
    repeat (10) @(negedge clk);
    rst_n = 1'b1;
    check("short", {pc, gc}, old);
    wait_ready();
    check("short", {pc, gc}, old);
  endtask
  task automatic t_codes();
    for (int p = 0; p < 4; p++)
      for (int j = 0; j < 3; j++)
      begin
        send(4'h0, {p[1:0], gains[j]});
        check("codes", {pc, gc}, {p[1:0], gains[j]});
      end
  endtask
  task automatic t_tx();
    tx = 1'b1;
    repeat (10) @(negedge clk);
    check("amp on", {7'h00, amp}, 8'h01);
    check("busy", {7'h00, rdy}, 8'h00);
    tx = 1'b0;
    repeat (10) @(negedge clk);
    check("amp off", {7'h00, amp}, 8'h00);
  endtask
  task automatic final_report();
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial
  begin
    #100000;
    num_errors++;
    final_report();
  end
  initial
  begin
    {rst_n, req, addr, data, tx} = '0;
    repeat (10) @(negedge clk);
    rst_n = 1'b1;
    t_defaults();
    t_ignore();
    t_codes();
    t_tx();
    t_short();
    final_report();
  end
endmodule
`default_nettype wire
